// ===== hw/twi_seq_regs.vh
// Offsets, field positions, status codes and timing counts of the two-wire
// master sequencer. Assumes a 250 MHz core clock and a 32-bit APB master.
//
// Behaviour
// RL1: Data sent, ACK: flag set, status 0x28
// RL2: Data sent, NOT ACK: flag, status 0x30
// RL3: In 0x28/0x30 new byte sent, ack sampled
// RL4: Clear with start only: repeated START
// RL5: Clear with stop only: STOP, stop bit cleared
// RL6: Start and stop: STOP then START, clear stop
// RL7: Arbitration lost in address/data: status 0x38
// RL8: 0x38, no start: release bus, not addressed
// RL9: 0x38 with start: wait free bus, START
// RL10: Address read/write bit selects transmit or receive
// RL11: Software requests START with pattern 1x10x10x
// RL12: START when bus free, then status 0x08
// RL13: Software loads address+read, clears with 1x00x10x
// RL14: After address+read: status 0x38, 0x40, 0x48
// RL15: Received byte in data register at flag
// RL16: Software NACKs the last wanted byte
// RL17: Software ends with STOP or repeated START
// RL18: Repeated START (0x10) keeps the bus
// RL19: Prescaler bits of status read zero
// RL20: Bus activity suspended while flag set
// RL21: Data write with flag low: ignored, collision
// RL22: Receive: ACK if ack enable, else NOT ACK
// RL23: Clock held low while flag set, owning
// RL24: Writing zero to flag has no effect
`ifndef TWI_SEQ_REGS_VH
`define TWI_SEQ_REGS_VH

`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_DATA       8'h08

`define CTRL_DONE       7
`define CTRL_ACKEN      6
`define CTRL_STA        5
`define CTRL_STO        4
`define CTRL_WCOL       3
`define CTRL_EN         2

`define ST_START        8'h08
`define ST_RSTART       8'h10
`define ST_AW_ACK       8'h18
`define ST_AW_NACK      8'h20
`define ST_DT_ACK       8'h28
`define ST_DT_NACK      8'h30
`define ST_ARB_LOST     8'h38
`define ST_AR_ACK       8'h40
`define ST_AR_NACK      8'h48
`define ST_DR_ACK       8'h50
`define ST_DR_NACK      8'h58
`define ST_NO_INFO      8'hF8

`define CLK_PERIOD_NS   4
`define SCL_QUARTER_NS  2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/pin_sync.v
// Two-flop synchroniser for pins from outside the core clock domain.
// Assumes nothing but a free-running core_clk.
module pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // Idle bus level is high, so reset to ones avoids a false START
  always @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff <= {WIDTH{1'b1}};
      sync_ff <= {WIDTH{1'b1}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // pin_sync

// ===== hw/scl_tick.v
// Quarter-bit tick for the serial clock.
// Free running; the sequencer waits for it between bus phases.
module scl_tick #(
  parameter CYC = 625
) (
  input  wire core_clk,
  input  wire sys_rst,
  output wire tick
);
  localparam integer LAST_I = CYC - 1;
  localparam [15:0]  LAST   = LAST_I[15:0];

  reg [15:0] cnt_ff;
  reg        tick_ff;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;
endmodule // scl_tick

// ===== hw/twi_master_seq.v
// Two-wire bus master sequencer with APB register access.
// Assumes open-drain pads outside: an enable high pulls the line low.
`include "twi_seq_regs.vh"

module twi_master_seq #(
  parameter QUARTER_CYC = `SCL_QUARTER_CYC
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe
);
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_WFREE = 3'd1;
  localparam [2:0] S_START = 3'd2;
  localparam [2:0] S_BYTE  = 3'd3;
  localparam [2:0] S_STOP  = 3'd4;
  localparam [2:0] S_HOLD  = 3'd5;

  reg [31:0] prdata_ff;
  reg        pready_ff;
  reg        pslverr_ff;
  reg        low_ff;
  reg        scl_oe_ff;
  reg        sda_oe_ff;
  reg        en_ff;
  reg        ea_ff;
  reg        sta_ff;
  reg        sto_ff;
  reg        wcol_ff;
  reg        flag_ff;
  reg [7:0]  data_ff;
  reg [7:0]  status_ff;
  reg [2:0]  state_ff;
  reg [1:0]  ph_ff;
  reg [3:0]  bit_ff;
  reg [7:0]  sh_ff;
  reg        ack_ff;
  reg        own_ff;
  reg        addr_next_ff;
  reg        cur_addr_ff;
  reg        rw_ff;
  reg        rx_ff;
  reg        one_out_ff;
  reg        busy_ff;
  reg        scl_d_ff;
  reg        sda_d_ff;

  wire       scl_s;
  wire       sda_s;
  wire       tick;
  wire       access;
  wire       mapped;
  wire       wr;
  wire       ctrl_wr;
  wire       data_wr;
  wire       go;
  wire       adv;
  wire       tx_byte;
  wire       start_seen;
  wire       stop_seen;
  wire [7:0] done_code;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `ADDR_CTRL) || (a == `ADDR_STATUS) || (a == `ADDR_DATA);
    end
  endfunction

  // Status after a whole byte and its acknowledge bit
  function [7:0] byte_code;
    input is_addr;
    input rw;
    input rx;
    input ack;
    begin
      if (is_addr && rw)
        byte_code = ack ? `ST_AR_ACK : `ST_AR_NACK;
      else if (is_addr)
        byte_code = ack ? `ST_AW_ACK : `ST_AW_NACK;
      else if (rx)
        byte_code = ack ? `ST_DR_ACK : `ST_DR_NACK;
      else
        byte_code = ack ? `ST_DT_ACK : `ST_DT_NACK;
    end
  endfunction

  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      ({scl_i, sda_i}),
    .dout     ({scl_s, sda_s})
  );

  scl_tick #(
    .CYC (QUARTER_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (tick)
  );

  // One wait state keeps pready and prdata registered
  assign access  = psel & penable & ~pready_ff;
  assign mapped  = is_mapped(paddr);
  assign wr      = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign ctrl_wr = wr & (paddr == `ADDR_CTRL);
  assign data_wr = wr & (paddr == `ADDR_DATA);
  // RL24 only a one clears
  assign go      = ctrl_wr & pwdata[`CTRL_DONE] & pwdata[`CTRL_EN];
  // Clock stretching by a target holds phase 2 until the released line is high
  assign adv     = tick & ((ph_ff != 2'd2) | scl_s);
  assign tx_byte = ~rx_ff | cur_addr_ff;
  assign start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_seen  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign done_code  = byte_code(cur_addr_ff, rw_ff, rx_ff, ack_ff);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access & ~mapped;
      if (access & ~pwrite) begin
        case (paddr)
          `ADDR_CTRL:
            prdata_ff <= {24'h000000, flag_ff, ea_ff, sta_ff, sto_ff,
                          wcol_ff, en_ff, 2'b00};
          // RL19 prescaler bits zero
          `ADDR_STATUS: prdata_ff <= {24'h000000, status_ff[7:3], 3'b000};
          `ADDR_DATA:   prdata_ff <= {24'h000000, data_ff};
          default:      prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // Bus monitor; another master's traffic marks the bus busy
  always @(posedge core_clk) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      busy_ff  <= 1'b0;
      low_ff   <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      low_ff   <= 1'b0;
      if (start_seen)
        busy_ff <= 1'b1;
      else if (stop_seen)
        busy_ff <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      en_ff        <= 1'b0;
      ea_ff        <= 1'b0;
      sta_ff       <= 1'b0;
      sto_ff       <= 1'b0;
      wcol_ff      <= 1'b0;
      flag_ff      <= 1'b0;
      data_ff      <= 8'hFF;
      status_ff    <= `ST_NO_INFO;
      state_ff     <= S_IDLE;
      ph_ff        <= 2'd0;
      bit_ff       <= 4'd0;
      sh_ff        <= 8'h00;
      ack_ff       <= 1'b0;
      own_ff       <= 1'b0;
      addr_next_ff <= 1'b0;
      cur_addr_ff  <= 1'b0;
      rw_ff        <= 1'b0;
      rx_ff        <= 1'b0;
      one_out_ff   <= 1'b0;
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        en_ff  <= pwdata[`CTRL_EN];
        ea_ff  <= pwdata[`CTRL_ACKEN];
        sta_ff <= pwdata[`CTRL_STA];
        sto_ff <= pwdata[`CTRL_STO];
      end
      if (go)
        flag_ff <= 1'b0;
      // RL21 collision on early write
      if (data_wr & ~flag_ff)
        wcol_ff <= 1'b1;
      else if (data_wr) begin
        wcol_ff <= 1'b0;
        data_ff <= pwdata[7:0];
      end

      if (ctrl_wr ? ~pwdata[`CTRL_EN] : ~en_ff) begin
        state_ff  <= S_IDLE;
        own_ff    <= 1'b0;
        flag_ff   <= 1'b0;
        scl_oe_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
        status_ff <= `ST_NO_INFO;
      end else begin
        case (state_ff)
          S_IDLE: begin
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            // RL11 start request
            if (go & pwdata[`CTRL_STA])
              state_ff <= S_WFREE;
          end
          S_WFREE: begin
            // RL9 wait for free bus
            if (~busy_ff & tick) begin
              state_ff <= S_START;
              ph_ff    <= 2'd0;
            end
          end
          S_START: begin
            if (adv) begin
              ph_ff <= ph_ff + 2'd1;
              case (ph_ff)
                2'd0: sda_oe_ff <= 1'b0;
                2'd1: scl_oe_ff <= 1'b0;
                2'd2: sda_oe_ff <= 1'b1;
                default: begin
                  scl_oe_ff    <= 1'b1;
                  // RL12 start done
                  // RL18 repeated start keeps bus
                  status_ff    <= own_ff ? `ST_RSTART : `ST_START;
                  flag_ff      <= 1'b1;
                  own_ff       <= 1'b1;
                  addr_next_ff <= 1'b1;
                  state_ff     <= S_HOLD;
                end
              endcase
            end
          end
          S_BYTE: begin
            if (adv) begin
              ph_ff <= ph_ff + 2'd1;
              case (ph_ff)
                2'd0: begin
                  if (bit_ff != 4'd8) begin
                    sda_oe_ff  <= tx_byte & ~sh_ff[7];
                    one_out_ff <= tx_byte & sh_ff[7];
                  end else begin
                    // RL22 ack from ack enable
                    sda_oe_ff  <= ~tx_byte & ea_ff;
                    one_out_ff <= ~tx_byte & ~ea_ff;
                  end
                end
                2'd1: scl_oe_ff <= 1'b0;
                2'd2: begin
                  if (one_out_ff & ~sda_s) begin
                    // RL7 arbitration lost
                    sda_oe_ff <= 1'b0;
                    own_ff    <= 1'b0;
                    flag_ff   <= 1'b1;
                    status_ff <= `ST_ARB_LOST;
                    state_ff  <= S_HOLD;
                  end else if (bit_ff != 4'd8)
                    sh_ff <= {sh_ff[6:0], sda_s};
                  else
                    ack_ff <= ~sda_s;
                end
                default: begin
                  scl_oe_ff <= 1'b1;
                  if (bit_ff == 4'd8) begin
                    // RL1 RL2 RL14 byte status
                    status_ff <= done_code;
                    flag_ff   <= 1'b1;
                    state_ff  <= S_HOLD;
                    // RL10 direction from address
                    if (cur_addr_ff)
                      rx_ff <= rw_ff;
                    // RL15 received byte readable
                    if (~tx_byte)
                      data_ff <= sh_ff;
                  end else
                    bit_ff <= bit_ff + 4'd1;
                end
              endcase
            end
          end
          S_STOP: begin
            if (adv) begin
              ph_ff <= ph_ff + 2'd1;
              case (ph_ff)
                2'd0: sda_oe_ff <= 1'b1;
                2'd1: scl_oe_ff <= 1'b0;
                2'd2: sda_oe_ff <= 1'b0;
                default: begin
                  // RL5 hardware clears stop
                  sto_ff    <= 1'b0;
                  own_ff    <= 1'b0;
                  rx_ff     <= 1'b0;
                  // RL6 start after stop
                  state_ff  <= sta_ff ? S_WFREE : S_IDLE;
                end
              endcase
            end
          end
          S_HOLD: begin
            // RL23 clock held low
            scl_oe_ff <= own_ff;
            // RL20 suspended until cleared
            if (go) begin
              status_ff <= `ST_NO_INFO;
              ph_ff     <= 2'd0;
              if (~own_ff) begin
                // RL8 release or RL9 restart
                scl_oe_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
                state_ff  <= pwdata[`CTRL_STA] ? S_WFREE : S_IDLE;
              end else if (pwdata[`CTRL_STO])
                state_ff <= S_STOP;
              else if (pwdata[`CTRL_STA])
                // RL4 repeated start
                state_ff <= S_START;
              else begin
                // RL3 send loaded byte
                state_ff     <= S_BYTE;
                sh_ff        <= data_ff;
                rw_ff        <= data_ff[0];
                cur_addr_ff  <= addr_next_ff;
                addr_next_ff <= 1'b0;
                bit_ff       <= 4'd0;
              end
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign scl_o   = low_ff;
  assign sda_o   = low_ff;
  assign scl_oe  = scl_oe_ff;
  assign sda_oe  = sda_oe_ff;
endmodule // twi_master_seq

// ===== tb/twi_master_seq_props.sv
// Checker for the two-wire master sequencer: APB timing and bus line drive.
// Assumes it is bound to twi_master_seq and sees only that module's ports.
`include "twi_seq_regs.vh"
module twi_master_seq_props #(
  parameter QUARTER_CYC = 4
) (
  input wire        core_clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scl_i,
  input wire        scl_o,
  input wire        scl_oe,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QHI = QUARTER_CYC + 2;
  logic [15:0] low_cnt_ff;
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == `ADDR_CTRL;
  wire mapped  = paddr == `ADDR_CTRL || paddr == `ADDR_STATUS || paddr == `ADDR_DATA;
  // A low longer than three bit phases can only be a stretch
  always @(posedge core_clk) begin
    if (sys_rst || !scl_oe || ctrl_wr) low_cnt_ff <= 16'h0000;
    else if (low_cnt_ff != 16'hFFFF) low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_err_rdzero: assert property (pready && !mapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_presc: assert property (pready && !pwrite && paddr == `ADDR_STATUS
    |-> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("status low bits not zero");
  a_stretch_hold: assert property (low_cnt_ff > 3 * QUARTER_CYC && !ctrl_wr |=> scl_oe)
    else $error("clock released without software");
  a_rst_release: assert property ($fell(sys_rst) |-> !scl_oe && !sda_oe && !pready)
    else $error("lines driven after reset");
  a_start_order: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:QHI] scl_oe)
    else $error("clock not pulled low after start");
  a_stop_idle: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe [*2])
    else $error("clock driven right after stop");
  a_pins_zero: assert property (!scl_o && !sda_o)
    else $error("drive value not low");
  cover property (pready && pslverr);
  cover property (low_cnt_ff > 3 * QUARTER_CYC);
  cover property ($fell(sda_oe) && !scl_oe);
endmodule // twi_master_seq_props

bind twi_master_seq twi_master_seq_props #(.QUARTER_CYC(QUARTER_CYC)) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe));

// ===== tb/twi_target_model.sv
// Behavioural bus target: acks its address, takes bytes, gives counting bytes.
// Assumes a pulled-up bus; it only pulls sda low and never stretches scl.
module twi_target_model #(
  parameter [6:0] DEV_ADDR = 7'h2A
) (
  input  wire        scl,
  input  wire        sda,
  input  wire        nack_data,
  input  wire        arb_pull,
  output wire        sda_pull,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx_byte = 8'hA5;
  logic       busy = 0, ph = 0, rd = 0, drv = 0;
  int         bitn = 0;
  assign sda_pull = drv | arb_pull;
  initial rx_byte = 8'h00;
  always @(negedge sda) if (scl) begin busy = 1; ph = 0; rd = 0; bitn = 0; drv = 0; end
  always @(posedge sda) if (scl) begin busy = 0; drv = 0; end
  // A high ack bit from the master ends our read data
  always @(posedge scl) if (busy) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (sda) rd = 0;
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end
  // Ack slot decided after eight bits
  always @(negedge scl) if (busy) begin
    drv = 0;
    if (bitn == 8 && !ph) begin
      drv = sh[7:1] == DEV_ADDR;
      rd = sh[0] && drv;
      ph = 1;
    end else if (bitn == 8 && !rd) begin
      rx_byte = sh;
      drv = !nack_data;
    end else if (bitn == 8) tx_byte = tx_byte + 8'h11;
    else if (rd) drv = !tx_byte[7 - bitn];
  end
endmodule // twi_target_model

// ===== tb/test_twi_master_seq.sv
// Testbench for the two-wire master sequencer: APB sequences against a target.
// Assumes a pulled-up bus, resolved here from the pull-downs of both parties.
`include "twi_seq_regs.vh"
module test_twi_master_seq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [6:0] DEV = 7'h2A;
  logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd_q;
  logic        nack_data = 0, arb_pull = 0, last_err;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_oe, sda_oe, tgt_pull;
  wire  [7:0]  rx_byte;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || tgt_pull);
  int          n_errors = 0, samples_checked = 0;
  // An 80 ns bus clock keeps bytes near 180 cycles
  twi_master_seq #(.QUARTER_CYC(5)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe));
  twi_target_model #(.DEV_ADDR(DEV)) u_tgt (
    .scl(scl), .sda(sda), .nack_data(nack_data), .arb_pull(arb_pull),
    .sda_pull(tgt_pull), .rx_byte(rx_byte));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin n_errors++; test_done(); end
    rd_q = prdata;
    last_err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin apb(0, `ADDR_CTRL, 0); n++; end while (rd_q[b] !== v && n < 300);
    if (n >= 300) begin n_errors++; test_done(); end
  endtask
  task automatic fin(input logic [7:0] s);
    poll(`CTRL_DONE, 1);
    apb(0, `ADDR_STATUS, 0);
    chk("status", rd_q, {24'h0, s});
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] s);
    apb(1, `ADDR_CTRL, {24'h0, c});
    fin(s);
  endtask
  task automatic ld(input logic [7:0] b);
    apb(1, `ADDR_DATA, {24'h0, b});
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 0;
    apb(0, `ADDR_CTRL, 0); chk("ctrl", rd_q, 32'h0);
    apb(0, `ADDR_STATUS, 0); chk("status", rd_q, 32'hF8);
    ld(8'h55); apb(0, `ADDR_DATA, 0); chk("data", rd_q, 32'hFF);
    apb(0, `ADDR_CTRL, 0); chk("collision", rd_q[`CTRL_WCOL], 32'h1);
    apb(0, 8'h0C, 0); chk("slverr", last_err, 32'h1);
    go(8'hA4, `ST_START);
    ld({DEV, 1'b0}); go(8'h84, `ST_AW_ACK);
    ld(8'h3C); go(8'h84, `ST_DT_ACK);
    chk("target byte", rx_byte, 32'h3C);
    apb(1, `ADDR_CTRL, 32'h04); apb(0, `ADDR_CTRL, 0);
    chk("flag", rd_q[`CTRL_DONE], 32'h1);
    chk("collision", rd_q[`CTRL_WCOL], 32'h0);
    chk("clock held", scl_oe, 32'h1);
    nack_data <= 1; ld(8'hC3); go(8'h84, `ST_DT_NACK);
    nack_data <= 0; ld(8'h5A); go(8'h84, `ST_DT_ACK);
    chk("target byte", rx_byte, 32'h5A);
    go(8'hA4, `ST_RSTART);
    ld({DEV, 1'b1}); go(8'h84, `ST_AR_ACK);
    go(8'hC4, `ST_DR_ACK);
    apb(0, `ADDR_DATA, 0); chk("rx data", rd_q, 32'hA5);
    go(8'h84, `ST_DR_NACK);
    apb(0, `ADDR_DATA, 0); chk("rx data", rd_q, 32'hB6);
    apb(1, `ADDR_CTRL, 32'h94); poll(`CTRL_STO, 0);
    chk("lines", {scl_oe, sda_oe}, 32'h0);
    go(8'hA4, `ST_START);
    ld({~DEV, 1'b0}); go(8'h84, `ST_AW_NACK);
    go(8'hB4, `ST_START);
    apb(0, `ADDR_CTRL, 0); chk("stop bit", rd_q[`CTRL_STO], 32'h0);
    ld({DEV, 1'b0}); go(8'h84, `ST_AW_ACK);
    arb_pull <= 1; ld(8'hFF); go(8'h84, `ST_ARB_LOST);
    apb(1, `ADDR_CTRL, 32'h84); apb(0, `ADDR_STATUS, 0);
    chk("status", rd_q, 32'hF8);
    chk("lines", {scl_oe, sda_oe}, 32'h0);
    // Competitor lets go with scl high, which frees the bus
    arb_pull <= 0; go(8'hA4, `ST_START);
    arb_pull <= 1; ld({DEV, 1'b1}); go(8'h84, `ST_ARB_LOST);
    apb(1, `ADDR_CTRL, 32'hA4);
    repeat (10) apb(0, `ADDR_STATUS, 0);
    chk("waiting", {sda_oe, rd_q[7:0]}, 32'hF8);
    arb_pull <= 0; fin(`ST_START);
    apb(1, `ADDR_CTRL, 32'h94); poll(`CTRL_STO, 0);
    test_done();
  end
endmodule // test_twi_master_seq
